// File: ptimer_pair_regs.sv
// AHB-Lite register slice and timer 2/3 pair counting logic
`timescale 1ns/10ps
`default_nettype none
module ptimer_pair_regs #(
   parameter int FILTER_CYCLES = ptimer_pkg::FILTER_DEFAULT
) (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        ce,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output var  logic [31:0] hrdata,
   output var  logic        hreadyout,
   output var  logic        hresp,
   input  wire logic        event_pin,
   input  wire logic        count_tick,
   input  wire logic [7:0]  timer0_count,
   input  wire logic [7:0]  timer1_count,
   input  wire logic [7:0]  timer2_compare,
   input  wire logic [7:0]  timer3_compare,
   input  wire logic [7:0]  timer3_reload,
   output var  logic [7:0]  timer0_compare,
   output var  logic [7:0]  timer1_compare,
   output var  logic [7:0]  timer2_count,
   output var  logic [7:0]  timer3_count,
   output var  logic        pair_timer_output
);
   localparam int FW = (FILTER_CYCLES > 1) ? $clog2(FILTER_CYCLES) : 1;

   function automatic logic hit(input logic [15:0] idx,
                                input logic [15:0] target);
      hit = (idx == target);
   endfunction : hit

   // Bus state
   logic                    addr_ok;
   logic                    wr_pend_reg;
   logic                    rd_pend_reg;
   logic [15:0]             idx_reg;
   logic [3:0]              wnib;
   logic [3:0]              rd_nibble;

   // Register contents
   logic [7:0]              t2_reload_reg;
   ptimer_pkg::mode_cfg_type mode_reg;
   ptimer_pkg::out_cfg_type  out_reg;
   logic                    run2_reg;
   logic                    run3_reg;

   // Counting state
   logic                    ev_meta_reg;
   logic                    ev_sync_reg;
   logic                    ev_filt_reg;
   logic                    ev_prev_reg;
   logic [FW-1:0]           stab_reg;
   logic                    ev_edge;
   logic                    t2_out_reg;
   logic                    t3_out_reg;
   logic                    run2_eff;
   logic                    t2_adv;
   logic                    t3_adv;
   logic                    t2_under;
   logic                    t3_under;
   logic                    reload2;
   logic                    reload3;
   logic                    ctrl_wr;

   assign addr_ok = hsel && hready && htrans[1];
   assign wnib    = hwdata[3:0];
   assign ctrl_wr = wr_pend_reg && hit(idx_reg, ptimer_pkg::IDX_RUN_CTRL);

   // Writes complete with no wait; reads add one wait state so that a read
   // right after a write sees the written value.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_reg <= 1'b0;
         rd_pend_reg <= 1'b0;
         idx_reg     <= 16'h0000;
         hreadyout   <= 1'b1;
         hrdata      <= 32'h0000_0000;
         hresp       <= 1'b0;
      end else if (ce) begin
         hresp       <= 1'b0;
         wr_pend_reg <= addr_ok && hwrite;
         if (addr_ok) begin
            idx_reg <= haddr[ptimer_pkg::IDX_MSB:ptimer_pkg::IDX_LSB];
         end
         if (addr_ok && !hwrite) begin
            rd_pend_reg <= 1'b1;
            hreadyout   <= 1'b0;
         end else if (rd_pend_reg) begin
            rd_pend_reg <= 1'b0;
            hreadyout   <= 1'b1;
            hrdata      <= {28'h0000000, rd_nibble};
         end
      end
   end

   // Read mux; reload strobes are write-only and read as zero
   always_comb begin
      rd_nibble = 4'h0;
      case (idx_reg)
         ptimer_pkg::IDX_T0_CMP_LO: rd_nibble = timer0_compare[3:0];
         ptimer_pkg::IDX_T0_CMP_HI: rd_nibble = timer0_compare[7:4];
         ptimer_pkg::IDX_T1_CMP_LO: rd_nibble = timer1_compare[3:0];
         ptimer_pkg::IDX_T1_CMP_HI: rd_nibble = timer1_compare[7:4];
         ptimer_pkg::IDX_MODE_CFG:  rd_nibble = mode_reg;
         ptimer_pkg::IDX_OUT_CFG:   rd_nibble = out_reg;
         ptimer_pkg::IDX_RUN_CTRL:
            rd_nibble = {1'b0, run3_reg, 1'b0, run2_reg};
         ptimer_pkg::IDX_T2_RLD_LO: rd_nibble = t2_reload_reg[3:0];
         ptimer_pkg::IDX_T2_RLD_HI: rd_nibble = t2_reload_reg[7:4];
         ptimer_pkg::IDX_T0_CNT_LO: rd_nibble = timer0_count[3:0];
         ptimer_pkg::IDX_T0_CNT_HI: rd_nibble = timer0_count[7:4];
         ptimer_pkg::IDX_T1_CNT_LO: rd_nibble = timer1_count[3:0];
         ptimer_pkg::IDX_T1_CNT_HI: rd_nibble = timer1_count[7:4];
         ptimer_pkg::IDX_T2_CNT_LO: rd_nibble = timer2_count[3:0];
         ptimer_pkg::IDX_T2_CNT_HI: rd_nibble = timer2_count[7:4];
         ptimer_pkg::IDX_T3_CNT_LO: rd_nibble = timer3_count[3:0];
         ptimer_pkg::IDX_T3_CNT_HI: rd_nibble = timer3_count[7:4];
         default:                   rd_nibble = 4'h0;
      endcase
   end

   // Compare and reload data registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         timer0_compare <= ptimer_pkg::BYTE_RESET;
         timer1_compare <= ptimer_pkg::BYTE_RESET;
         t2_reload_reg  <= ptimer_pkg::BYTE_RESET;
      end else if (ce && wr_pend_reg) begin
         if (hit(idx_reg, ptimer_pkg::IDX_T0_CMP_LO)) begin
            timer0_compare[3:0] <= wnib;
         end
         if (hit(idx_reg, ptimer_pkg::IDX_T0_CMP_HI)) begin
            timer0_compare[7:4] <= wnib;
         end
         if (hit(idx_reg, ptimer_pkg::IDX_T1_CMP_LO)) begin
            timer1_compare[3:0] <= wnib;
         end
         if (hit(idx_reg, ptimer_pkg::IDX_T1_CMP_HI)) begin
            timer1_compare[7:4] <= wnib;
         end
         if (hit(idx_reg, ptimer_pkg::IDX_T2_RLD_LO)) begin
            t2_reload_reg[3:0] <= wnib;
         end
         if (hit(idx_reg, ptimer_pkg::IDX_T2_RLD_HI)) begin
            t2_reload_reg[7:4] <= wnib;
         end
      end
   end

   // Mode, output and run configuration
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mode_reg <= ptimer_pkg::MODE_RESET;
         out_reg  <= ptimer_pkg::OUT_RESET;
         run2_reg <= 1'b0;
         run3_reg <= 1'b0;
      end else if (ce && wr_pend_reg) begin
         if (hit(idx_reg, ptimer_pkg::IDX_MODE_CFG)) begin
            mode_reg <= ptimer_pkg::mode_cfg_type'(wnib);
         end
         if (hit(idx_reg, ptimer_pkg::IDX_OUT_CFG)) begin
            out_reg <= ptimer_pkg::out_cfg_type'(wnib);
         end
         if (ctrl_wr) begin
            run3_reg <= wnib[ptimer_pkg::CTRL_RUN3_BIT];
            run2_reg <= wnib[ptimer_pkg::CTRL_RUN2_BIT];
         end
      end
   end

   // External count input: synchroniser, optional stability filter, edge
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ev_meta_reg <= 1'b0;
         ev_sync_reg <= 1'b0;
         ev_filt_reg <= 1'b0;
         ev_prev_reg <= 1'b0;
         stab_reg    <= '0;
      end else if (ce) begin
         ev_meta_reg <= event_pin;
         ev_sync_reg <= ev_meta_reg;
         ev_prev_reg <= ev_filt_reg;
         if (ev_sync_reg == ev_filt_reg) begin
            stab_reg <= '0;
         end else if (!mode_reg.input_filter_select ||
                      stab_reg == FW'(FILTER_CYCLES - 1)) begin
            ev_filt_reg <= ev_sync_reg;
            stab_reg    <= '0;
         end else begin
            stab_reg <= stab_reg + FW'(1);
         end
      end
   end

   assign ev_edge = mode_reg.count_edge_polarity ?
                    (ev_filt_reg && !ev_prev_reg) :
                    (!ev_filt_reg && ev_prev_reg);

   // In cascade the timer 3 controls govern the pair
   assign run2_eff = mode_reg.cascade ? run3_reg : run2_reg;
   assign t2_adv   = run2_eff &&
                     (mode_reg.event_count_select ? ev_edge
                                                  : count_tick);
   assign t2_under = t2_adv && (timer2_count == ptimer_pkg::BYTE_RESET);
   assign t3_adv   = mode_reg.cascade ? t2_under
                                      : (run3_reg && count_tick);
   assign t3_under = t3_adv && (timer3_count == ptimer_pkg::BYTE_RESET);
   assign reload3  = ctrl_wr && wnib[ptimer_pkg::CTRL_RST3_BIT];
   assign reload2  = (ctrl_wr && wnib[ptimer_pkg::CTRL_RST2_BIT]) ||
                     (mode_reg.cascade && reload3);

   // Timer 2 counter
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         timer2_count <= ptimer_pkg::BYTE_RESET;
      end else if (ce) begin
         if (reload2) begin
            timer2_count <= t2_reload_reg;
         end else if (t2_under) begin
            timer2_count <= t2_reload_reg;
         end else if (t2_adv) begin
            timer2_count <= timer2_count - ptimer_pkg::COUNT_STEP;
         end
      end
   end

   // Timer 3 counter; advances on timer 2 underflow in cascade
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         timer3_count <= ptimer_pkg::BYTE_RESET;
      end else if (ce) begin
         if (reload3) begin
            timer3_count <= timer3_reload;
         end else if (t3_under) begin
            timer3_count <= timer3_reload;
         end else if (t3_adv) begin
            timer3_count <= timer3_count - ptimer_pkg::COUNT_STEP;
         end
      end
   end

   // Timer outputs: toggle on underflow, or PWM set on match, clear at wrap
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         t2_out_reg <= 1'b0;
         t3_out_reg <= 1'b0;
      end else if (ce) begin
         if (reload2) begin
            t2_out_reg <= 1'b0;
         end else if (out_reg.timer2_pwm_select) begin
            if (t2_under) begin
               t2_out_reg <= 1'b0;
            end else if (timer2_count == timer2_compare) begin
               t2_out_reg <= 1'b1;
            end
         end else if (t2_under) begin
            t2_out_reg <= !t2_out_reg;
         end
         if (reload3) begin
            t3_out_reg <= 1'b0;
         end else if (out_reg.timer3_pwm_select) begin
            if (t3_under) begin
               t3_out_reg <= 1'b0;
            end else if (timer3_count == timer3_compare) begin
               t3_out_reg <= 1'b1;
            end
         end else if (t3_under) begin
            t3_out_reg <= !t3_out_reg;
         end
      end
   end

   // Shared pair output
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pair_timer_output <= 1'b0;
      end else if (ce) begin
         if (!out_reg.pair_output_enable) begin
            pair_timer_output <= 1'b0;
         end else begin
            pair_timer_output <= out_reg.pair_output_source ?
                                 t3_out_reg : t2_out_reg;
         end
      end
   end

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   a_cascade_carry: assert property (
      (ce && mode_reg.cascade && t2_under && !reload3 &&
       timer3_count != 8'h00)
      |=> timer3_count == $past(timer3_count) - 8'h01)
      else $error("timer 3 did not advance on timer 2 underflow");

   a_split_hold: assert property (
      (ce && !mode_reg.cascade && !(run3_reg && count_tick) && !reload3)
      |=> $stable(timer3_count))
      else $error("timer 3 moved without its own tick");

   a_stop_freeze: assert property (
      (ce && !run2_eff && !reload2) |=> $stable(timer2_count))
      else $error("timer 2 moved while stopped");

   a_run3_freeze: assert property (
      (ce && !mode_reg.cascade && !run3_reg && !reload3)
      |=> $stable(timer3_count))
      else $error("timer 3 moved while stopped");

   a_event_count: assert property (
      (ce && mode_reg.event_count_select && run2_eff && ev_edge &&
       !reload2 && timer2_count != 8'h00)
      |=> timer2_count == $past(timer2_count) - 8'h01)
      else $error("event edge not counted");

   a_event_ignores_tick: assert property (
      (ce && mode_reg.event_count_select && !ev_edge && !reload2)
      |=> $stable(timer2_count))
      else $error("event counter advanced without an edge");

   a_edge_rising: assert property (
      (ce && mode_reg.event_count_select && mode_reg.count_edge_polarity &&
       ev_prev_reg && !ev_filt_reg && !reload2)
      |=> $stable(timer2_count))
      else $error("falling edge counted in rising mode");

   a_filter_hold: assert property (
      (ce && mode_reg.input_filter_select && ev_sync_reg != ev_filt_reg &&
       stab_reg != FW'(FILTER_CYCLES - 1))
      |=> $stable(ev_filt_reg))
      else $error("filtered input changed too early");

   a_reload2_load: assert property (
      (ce && reload2) |=> timer2_count == $past(t2_reload_reg))
      else $error("timer 2 reload strobe did not load");

   a_reload3_load: assert property (
      (ce && reload3) |=> timer3_count == $past(timer3_reload))
      else $error("timer 3 reload strobe did not load");

   a_output_off: assert property (
      (ce && !out_reg.pair_output_enable) |=> !pair_timer_output)
      else $error("pair output driven while disabled");

   a_output_select: assert property (
      (ce && out_reg.pair_output_enable && out_reg.pair_output_source)
      |=> pair_timer_output == $past(t3_out_reg))
      else $error("pair output not from timer 3");

   a_normal_toggle: assert property (
      (ce && !out_reg.timer3_pwm_select && t3_under && !reload3)
      |=> t3_out_reg != $past(t3_out_reg))
      else $error("timer 3 output did not toggle on underflow");

   a_pwm_match: assert property (
      (ce && out_reg.timer2_pwm_select && !t2_under && !reload2 &&
       timer2_count == timer2_compare)
      |=> t2_out_reg)
      else $error("timer 2 PWM output not set on match");

   a_read_wait: assert property (
      (ce && addr_ok && !hwrite) |=> !hreadyout ##1 (hreadyout || !ce))
      else $error("read answer not after one wait state");

   c_cascade_carry: cover property (ce && mode_reg.cascade && t2_under);
   c_event_edge: cover property (ce && mode_reg.event_count_select &&
                                 t2_adv);
   c_pwm_match: cover property (ce && out_reg.timer3_pwm_select &&
                                t3_out_reg && pair_timer_output);
   c_bus_read: cover property (ce && rd_pend_reg);
endmodule : ptimer_pair_regs
`default_nettype wire

// File: ptimer_pkg.sv
// Constants and carrier types for the timer pair control register slice
package ptimer_pkg;
   // Register indices; byte address is four times the index
   localparam logic [15:0] IDX_T0_CMP_LO  = 16'hff8c;
   localparam logic [15:0] IDX_T0_CMP_HI  = 16'hff8d;
   localparam logic [15:0] IDX_T1_CMP_LO  = 16'hff8e;
   localparam logic [15:0] IDX_T1_CMP_HI  = 16'hff8f;
   localparam logic [15:0] IDX_MODE_CFG   = 16'hff90;
   localparam logic [15:0] IDX_OUT_CFG    = 16'hff91;
   localparam logic [15:0] IDX_RUN_CTRL   = 16'hff92;
   localparam logic [15:0] IDX_T2_RLD_LO  = 16'hff94;
   localparam logic [15:0] IDX_T2_RLD_HI  = 16'hff95;
   localparam logic [15:0] IDX_T0_CNT_LO  = 16'hff88;
   localparam logic [15:0] IDX_T0_CNT_HI  = 16'hff89;
   localparam logic [15:0] IDX_T1_CNT_LO  = 16'hff8a;
   localparam logic [15:0] IDX_T1_CNT_HI  = 16'hff8b;
   localparam logic [15:0] IDX_T2_CNT_LO  = 16'hff98;
   localparam logic [15:0] IDX_T2_CNT_HI  = 16'hff99;
   localparam logic [15:0] IDX_T3_CNT_LO  = 16'hff9a;
   localparam logic [15:0] IDX_T3_CNT_HI  = 16'hff9b;
   localparam int          IDX_LSB        = 2;
   localparam int          IDX_MSB        = 17;
   // Run and reload control bit positions
   localparam int          CTRL_RST3_BIT  = 3;
   localparam int          CTRL_RUN3_BIT  = 2;
   localparam int          CTRL_RST2_BIT  = 1;
   localparam int          CTRL_RUN2_BIT  = 0;
   localparam logic [3:0]  NIBBLE_RESET   = 4'h0;
   localparam logic [7:0]  BYTE_RESET     = 8'h00;
   localparam logic [7:0]  COUNT_STEP     = 8'h01;
   localparam int          FILTER_DEFAULT = 4;

   typedef struct packed {
      logic cascade;
      logic event_count_select;
      logic input_filter_select;
      logic count_edge_polarity;
   } mode_cfg_type;

   typedef struct packed {
      logic timer3_pwm_select;
      logic timer2_pwm_select;
      logic pair_output_source;
      logic pair_output_enable;
   } out_cfg_type;

   localparam mode_cfg_type MODE_RESET = '0;
   localparam out_cfg_type  OUT_RESET  = '0;
endpackage : ptimer_pkg

// File: tb_top.sv
// Self-checking testbench for the timer pair control register slice
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   logic        hclk;
   logic        hresetn;
   logic        ce;
   logic        hsel;
   logic [31:0] haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [2:0]  hsize;
   logic [31:0] hwdata;
   logic [31:0] hrdata;
   logic        hreadyout;
   logic        hresp;
   logic        event_pin;
   logic        count_tick;
   logic [7:0]  timer0_count;
   logic [7:0]  timer1_count;
   logic [7:0]  timer2_compare;
   logic [7:0]  timer3_compare;
   logic [7:0]  timer3_reload;
   logic [7:0]  timer0_compare;
   logic [7:0]  timer1_compare;
   logic [7:0]  timer2_count;
   logic [7:0]  timer3_count;
   logic        pair_timer_output;
   int          mismatches;
   int          n_checks;

   ptimer_pair_regs #(.FILTER_CYCLES(2)) DUT (
      .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .event_pin(event_pin),
      .count_tick(count_tick), .timer0_count(timer0_count),
      .timer1_count(timer1_count), .timer2_compare(timer2_compare),
      .timer3_compare(timer3_compare), .timer3_reload(timer3_reload),
      .timer0_compare(timer0_compare), .timer1_compare(timer1_compare),
      .timer2_count(timer2_count), .timer3_count(timer3_count),
      .pair_timer_output(pair_timer_output));

   initial begin
      hclk = 1'b0;
      forever #10 hclk = ~hclk;
   end

   task automatic summarize;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : summarize

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic cyc(input int n);
      repeat (n) @(posedge hclk);
   endtask : cyc

   // Single AHB transfer; index is a word index, byte address is 4x
   task automatic xfer(input logic [15:0] idx, input logic w,
                       input logic [3:0] d, output logic [31:0] q);
      @(posedge hclk);
      hsel   <= 1'b1;
      haddr  <= {14'h0000, idx, 2'b00};
      htrans <= 2'b10;
      hwrite <= w;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      hsel   <= 1'b0;
      htrans <= 2'b00;
      hwdata <= {28'h0000000, d};
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      q = hrdata;
      chk({31'h00000000, hresp}, 32'h00000000);
   endtask : xfer

   task automatic wr(input logic [15:0] idx, input logic [3:0] d);
      logic [31:0] q;
      xfer(idx, 1'b1, d, q);
   endtask : wr

   task automatic rd(input logic [15:0] idx, input logic [3:0] e);
      logic [31:0] q;
      xfer(idx, 1'b0, 4'h0, q);
      chk(q, {28'h0000000, e});
   endtask : rd

   // Ticks spaced two cycles apart; returns once the last one has landed
   task automatic tick(input int n);
      repeat (n) begin
         @(posedge hclk);
         count_tick <= 1'b1;
         @(posedge hclk);
         count_tick <= 1'b0;
      end
      @(posedge hclk);
   endtask : tick

   task automatic pin(input logic v);
      @(posedge hclk);
      event_pin <= v;
      cyc(10);
   endtask : pin

   task automatic t_reset;
      logic [15:0] idx [9];
      idx = '{ptimer_pkg::IDX_T0_CMP_LO, ptimer_pkg::IDX_T0_CMP_HI,
               ptimer_pkg::IDX_T1_CMP_LO, ptimer_pkg::IDX_T1_CMP_HI,
               ptimer_pkg::IDX_MODE_CFG, ptimer_pkg::IDX_OUT_CFG,
               ptimer_pkg::IDX_RUN_CTRL, ptimer_pkg::IDX_T2_RLD_LO,
               ptimer_pkg::IDX_T2_RLD_HI};
      foreach (idx[i]) rd(idx[i], 4'h0);
      chk({24'h000000, timer0_compare}, 32'h00000000);
   endtask : t_reset

   task automatic t_regs;
      wr(ptimer_pkg::IDX_T0_CMP_LO, 4'h5);
      wr(ptimer_pkg::IDX_T0_CMP_HI, 4'ha);
      wr(ptimer_pkg::IDX_T1_CMP_LO, 4'h3);
      wr(ptimer_pkg::IDX_T1_CMP_HI, 4'hc);
      rd(ptimer_pkg::IDX_T0_CMP_HI, 4'ha);
      rd(ptimer_pkg::IDX_T1_CMP_LO, 4'h3);
      chk({24'h000000, timer0_compare}, 32'h000000a5);
      chk({24'h000000, timer1_compare}, 32'h000000c3);
      wr(16'hff93, 4'hf);
      rd(16'hff93, 4'h0);
      rd(ptimer_pkg::IDX_T0_CNT_LO, 4'he);
      rd(ptimer_pkg::IDX_T1_CNT_HI, 4'h4);
   endtask : t_regs

   task automatic t_reload;
      wr(ptimer_pkg::IDX_T2_RLD_LO, 4'hc);
      wr(ptimer_pkg::IDX_T2_RLD_HI, 4'h3);
      rd(ptimer_pkg::IDX_T2_RLD_HI, 4'h3);
      wr(ptimer_pkg::IDX_RUN_CTRL, 4'h2);
      cyc(1);
      chk({24'h000000, timer2_count}, 32'h0000003c);
      rd(ptimer_pkg::IDX_RUN_CTRL, 4'h0);
      wr(ptimer_pkg::IDX_T2_CNT_LO, 4'h0);
      rd(ptimer_pkg::IDX_T2_CNT_LO, 4'hc);
      rd(ptimer_pkg::IDX_T2_CNT_HI, 4'h3);
      wr(ptimer_pkg::IDX_RUN_CTRL, 4'h1);
      tick(3);
      chk({24'h000000, timer2_count}, 32'h00000039);
      rd(ptimer_pkg::IDX_RUN_CTRL, 4'h1);
      wr(ptimer_pkg::IDX_RUN_CTRL, 4'h0);
      tick(2);
      chk({24'h000000, timer2_count}, 32'h00000039);
   endtask : t_reload

   task automatic t_output;
      wr(ptimer_pkg::IDX_T2_RLD_LO, 4'h1);
      wr(ptimer_pkg::IDX_T2_RLD_HI, 4'h0);
      wr(ptimer_pkg::IDX_RUN_CTRL, 4'h2);
      wr(ptimer_pkg::IDX_OUT_CFG, 4'h1);
      wr(ptimer_pkg::IDX_RUN_CTRL, 4'h1);
      tick(1);
      chk({31'h0, pair_timer_output}, 32'h0);
      tick(1);
      cyc(1);
      chk({24'h000000, timer2_count}, 32'h00000001);
      chk({31'h0, pair_timer_output}, 32'h1);
      wr(ptimer_pkg::IDX_RUN_CTRL, 4'h0);
      wr(ptimer_pkg::IDX_OUT_CFG, 4'h3);
      cyc(2);
      chk({31'h0, pair_timer_output}, 32'h0);
      wr(ptimer_pkg::IDX_OUT_CFG, 4'h1);
      cyc(2);
      chk({31'h0, pair_timer_output}, 32'h1);
      wr(ptimer_pkg::IDX_OUT_CFG, 4'h0);
      cyc(2);
      chk({31'h0, pair_timer_output}, 32'h0);
   endtask : t_output

   task automatic t_pwm;
      wr(ptimer_pkg::IDX_T2_RLD_LO, 4'h4);
      wr(ptimer_pkg::IDX_RUN_CTRL, 4'h2);
      wr(ptimer_pkg::IDX_OUT_CFG, 4'h5);
      wr(ptimer_pkg::IDX_RUN_CTRL, 4'h1);
      tick(1);
      cyc(2);
      chk({31'h0, pair_timer_output}, 32'h0);
      tick(1);
      cyc(2);
      chk({31'h0, pair_timer_output}, 32'h1);
      wr(ptimer_pkg::IDX_RUN_CTRL, 4'h0);
   endtask : t_pwm

   task automatic t_event;
      wr(ptimer_pkg::IDX_T2_RLD_LO, 4'h0);
      wr(ptimer_pkg::IDX_T2_RLD_HI, 4'h1);
      wr(ptimer_pkg::IDX_RUN_CTRL, 4'h2);
      wr(ptimer_pkg::IDX_MODE_CFG, 4'h5);
      wr(ptimer_pkg::IDX_RUN_CTRL, 4'h1);
      tick(2);
      chk({24'h000000, timer2_count}, 32'h00000010);
      pin(1'b1);
      chk({24'h000000, timer2_count}, 32'h0000000f);
      pin(1'b0);
      chk({24'h000000, timer2_count}, 32'h0000000f);
      wr(ptimer_pkg::IDX_MODE_CFG, 4'h4);
      pin(1'b1);
      chk({24'h000000, timer2_count}, 32'h0000000f);
      pin(1'b0);
      chk({24'h000000, timer2_count}, 32'h0000000e);
      wr(ptimer_pkg::IDX_MODE_CFG, 4'h5);
      @(posedge hclk);
      event_pin <= 1'b1;
      pin(1'b0);
      chk({24'h000000, timer2_count}, 32'h0000000d);
      wr(ptimer_pkg::IDX_MODE_CFG, 4'h7);
      @(posedge hclk);
      event_pin <= 1'b1;
      pin(1'b0);
      chk({24'h000000, timer2_count}, 32'h0000000d);
      pin(1'b1);
      pin(1'b0);
      chk({24'h000000, timer2_count}, 32'h0000000c);
      wr(ptimer_pkg::IDX_RUN_CTRL, 4'h0);
   endtask : t_event

   task automatic t_cascade;
      wr(ptimer_pkg::IDX_T2_RLD_HI, 4'h0);
      wr(ptimer_pkg::IDX_MODE_CFG, 4'h8);
      wr(ptimer_pkg::IDX_RUN_CTRL, 4'h8);
      cyc(1);
      chk({24'h000000, timer3_count}, 32'h00000005);
      chk({24'h000000, timer2_count}, 32'h00000000);
      wr(ptimer_pkg::IDX_RUN_CTRL, 4'h4);
      tick(1);
      chk({24'h000000, timer3_count}, 32'h00000004);
      rd(ptimer_pkg::IDX_RUN_CTRL, 4'h4);
      wr(ptimer_pkg::IDX_MODE_CFG, 4'h0);
      tick(1);
      chk({24'h000000, timer3_count}, 32'h00000003);
      chk({24'h000000, timer2_count}, 32'h00000000);
      rd(ptimer_pkg::IDX_T3_CNT_LO, 4'h3);
      wr(ptimer_pkg::IDX_OUT_CFG, 4'hb);
      cyc(2);
      chk({31'h0, pair_timer_output}, 32'h0);
      tick(1);
      cyc(2);
      chk({31'h0, pair_timer_output}, 32'h1);
      wr(ptimer_pkg::IDX_RUN_CTRL, 4'h0);
      tick(1);
      chk({24'h000000, timer3_count}, 32'h00000002);
   endtask : t_cascade

   // Timer 3 normal output, clock-enable freeze and a reset in mid-run
   task automatic t_freeze;
      wr(ptimer_pkg::IDX_OUT_CFG, 4'h3);
      wr(ptimer_pkg::IDX_RUN_CTRL, 4'hc);
      tick(5);
      cyc(2);
      chk({31'h0, pair_timer_output}, 32'h0);
      tick(1);
      cyc(2);
      chk({31'h0, pair_timer_output}, 32'h1);
      chk({24'h000000, timer3_count}, 32'h00000005);
      @(posedge hclk);
      ce <= 1'b0;
      tick(2);
      chk({24'h000000, timer3_count}, 32'h00000005);
      ce <= 1'b1;
      tick(1);
      chk({24'h000000, timer3_count}, 32'h00000004);
      hresetn <= 1'b0;
      cyc(2);
      chk({31'h0, pair_timer_output}, 32'h0);
      chk({24'h000000, timer0_compare}, 32'h00000000);
      hresetn <= 1'b1;
      rd(ptimer_pkg::IDX_RUN_CTRL, 4'h0);
      rd(ptimer_pkg::IDX_T2_RLD_HI, 4'h0);
      rd(ptimer_pkg::IDX_T1_CMP_HI, 4'h0);
   endtask : t_freeze

   initial begin
      mismatches = 0;
      n_checks = 0;
      hresetn = 1'b0;
      ce = 1'b1;
      hsel = 1'b0;
      haddr = 32'h00000000;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h00000000;
      event_pin = 1'b0;
      count_tick = 1'b0;
      timer0_count = 8'h9e;
      timer1_count = 8'h47;
      timer2_compare = 8'h02;
      timer3_compare = 8'h02;
      timer3_reload = 8'h05;
      cyc(10);
      hresetn <= 1'b1;
      t_reset();
      t_regs();
      t_reload();
      t_output();
      t_pwm();
      t_event();
      t_cascade();
      t_freeze();
      summarize();
   end

   // Whole run needs a few hundred cycles
   initial begin
      cyc(20000);
      mismatches++;
      summarize();
   end
endmodule : tb_top
`default_nettype wire
